// File: rtl/wakeup_irq_select_priority.sv
`timescale 1ns/1ps
`default_nettype none
// Wake interrupt source selection and low priority bits, AXI4-Lite slave
module wakeup_irq_select_priority
  import wakeup_irq_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  // Write address channel
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // Write data channel
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // Write response channel
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // Read address channel
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // Read data channel
  output logic [DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Asynchronous pins
  input wire logic CARD_DETECT_INPUT,
  input wire logic OUTPUT_ENABLE_INPUT,
  input wire logic RX_WAKE_INPUT,
  // Requests towards the core vectoring logic
  output logic CARD_DETECT_IRQ,
  output logic EXTERNAL_REQUEST_ONE,
  output logic RX_WAKE_IRQ,
  output logic [PRIO_LOW_WIDTH-1:0] PRIORITY_LOW,
  output logic IRQ
);

  // Bus and register state; flags and pin stages live in submodules
  typedef struct packed {
    logic aw_got; // Write address held
    logic [ADDR_W-1:0] aw_addr;
    logic w_got; // Write data held
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic b_valid; // Write response pending
    logic [1:0] b_resp;
    logic r_valid; // Read data pending
    logic [DATA_W-1:0] r_data;
    logic [1:0] r_resp;
    logic card_detect_level_select;
    logic output_enable_level_select;
    logic output_enable_irq_enable;
    logic card_detect_irq_enable;
    logic rx_wake_irq_enable;
    logic [PRIO_LOW_WIDTH-1:0] prio_low;
    logic [EVENT_COUNT-1:0] irq_mask;
    logic oe_prev; // Last output enable activity, for edge events
    logic rx_prev; // Last receive line level, for start edges
  } state_t;

  state_t s;
  state_t next_s;

  // Synchronised pins
  logic [2:0] pins_sync;
  logic card_sync;
  logic oe_sync;
  logic rx_sync;

  // Derived conditions
  logic card_cond; // Card presence at the selected level
  logic oe_active; // Output enable at the selected level
  logic rx_fall; // Start edge on the receive line

  // Sticky flags and event status
  logic [FLAG_COUNT-1:0] flag_set;
  logic [FLAG_COUNT-1:0] flag_clear;
  logic [FLAG_COUNT-1:0] flags;
  logic [EVENT_COUNT-1:0] events;
  logic [EVENT_COUNT-1:0] status_clear;
  logic [EVENT_COUNT-1:0] status;

  // Write decode results
  logic do_write;
  logic select_wr;
  logic [7:0] select_new;
  logic prio_wr;
  logic [7:0] prio_new;
  logic [7:0] select_read;
  logic [7:0] prio_read;
  logic [2:0] bit_index;

  // Pins come from outside the clock domain
  pin_sync #(
    .WIDTH(3),
    .RESET_VALUE(PIN_SYNC_RESET)
  ) u_pin_sync (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .pin_in({CARD_DETECT_INPUT, OUTPUT_ENABLE_INPUT, RX_WAKE_INPUT}),
    .pin_out(pins_sync)
  );

  assign card_sync = pins_sync[2];
  assign oe_sync = pins_sync[1];
  assign rx_sync = pins_sync[0];

  // Level select picks which input level means a card is present
  assign card_cond = s.card_detect_level_select ? card_sync // RULE2
                                                : !card_sync; // RULE1
  // Output enable level select, same sense as the card select
  assign oe_active = s.output_enable_level_select ? oe_sync : !oe_sync;
  assign rx_fall = s.rx_prev & !rx_sync;

  // Card and receive flags of the select register
  assign flag_set[FLAG_CD] = card_cond; // RULE3
  assign flag_set[FLAG_RX] = rx_fall;

  sticky_flags #(
    .WIDTH(FLAG_COUNT),
    .RESET_VALUE(FLAG_RESET)
  ) u_select_flags (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_in(flag_set),
    .clear_in(flag_clear),
    .flag(flags)
  );

  // New detections feed the status register, so a held level does
  // not refire right after software acknowledges it
  assign events[EV_CD] = card_cond & !flags[FLAG_CD];
  assign events[EV_OE] = oe_active & !s.oe_prev;
  assign events[EV_RX] = rx_fall;

  sticky_flags #(
    .WIDTH(EVENT_COUNT),
    .RESET_VALUE(IRQ_STATUS_RESET)
  ) u_event_status (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_in(events),
    .clear_in(status_clear),
    .flag(status)
  );

  // Current register images; reserved bits read as zero
  always_comb begin
    select_read = 8'h00;
    select_read[CD_LEVEL_BIT] = s.card_detect_level_select;
    select_read[CD_FLAG_BIT] = flags[FLAG_CD];
    select_read[RX_FLAG_BIT] = flags[FLAG_RX];
    select_read[OE_LEVEL_BIT] = s.output_enable_level_select;
    select_read[OE_EN_BIT] = s.output_enable_irq_enable;
    select_read[CD_EN_BIT] = s.card_detect_irq_enable;
    select_read[RX_EN_BIT] = s.rx_wake_irq_enable;
    prio_read = {3'h0, s.prio_low};
  end

  // Bus handling, write decode and next state
  always_comb begin
    next_s = s;
    do_write = s.aw_got & s.w_got & !s.b_valid;
    select_wr = 1'b0;
    select_new = select_read;
    prio_wr = 1'b0;
    prio_new = prio_read;
    status_clear = '0;
    bit_index = s.w_data[2:0];

    // Accept address and data in either order
    if (AWVALID && AWREADY) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_s.w_got = 1'b1;
      next_s.w_data = WDATA;
      next_s.w_strb = WSTRB;
    end

    // Both halves held: perform the write and answer
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.b_valid = 1'b1;
      next_s.b_resp = RESP_OKAY;
      if (s.aw_addr == SELECT_OFFSET) begin
        select_wr = s.w_strb[0];
        select_new = s.w_data[7:0];
      end else if (s.aw_addr == PRIO_LOW_OFFSET) begin
        prio_wr = s.w_strb[0]; // RULE9
        prio_new = s.w_data[7:0];
      end else if (s.aw_addr == IRQ_STATUS_OFFSET) begin
        // Write one to clear
        if (s.w_strb[0]) begin
          status_clear = s.w_data[EVENT_COUNT-1:0];
        end
      end else if (s.aw_addr == IRQ_MASK_OFFSET) begin
        if (s.w_strb[0]) begin
          next_s.irq_mask = s.w_data[EVENT_COUNT-1:0];
        end
      end else if (s.aw_addr == BIT_OP_OFFSET) begin
        // Single bit set or clear, as a bit instruction would do
        if (s.w_strb[0] && s.w_data[BIT_OP_TARGET_BIT]) begin
          prio_wr = 1'b1; // RULE10
          prio_new[bit_index] = s.w_data[BIT_OP_VALUE_BIT];
        end else if (s.w_strb[0]) begin
          select_wr = 1'b1;
          select_new[bit_index] = s.w_data[BIT_OP_VALUE_BIT];
        end
      end else begin
        // Unmapped address
        next_s.b_resp = RESP_SLVERR;
      end
    end

    // Response leaves once the master takes it
    if (s.b_valid && BREADY) begin
      next_s.b_valid = 1'b0;
    end

    // Read: data registered one cycle after the address
    if (ARVALID && ARREADY) begin
      next_s.r_valid = 1'b1;
      next_s.r_resp = RESP_OKAY;
      if (ARADDR == SELECT_OFFSET) begin
        next_s.r_data = {24'h000000, select_read};
      end else if (ARADDR == PRIO_LOW_OFFSET) begin
        next_s.r_data = {24'h000000, prio_read}; // RULE10
      end else if (ARADDR == IRQ_STATUS_OFFSET) begin
        next_s.r_data = {29'h00000000, status};
      end else if (ARADDR == IRQ_MASK_OFFSET) begin
        next_s.r_data = {29'h00000000, s.irq_mask};
      end else if (ARADDR == BIT_OP_OFFSET) begin
        next_s.r_data = 32'h00000000;
      end else begin
        next_s.r_data = 32'h00000000;
        next_s.r_resp = RESP_SLVERR;
      end
    end else if (s.r_valid && RREADY) begin
      next_s.r_valid = 1'b0;
    end

    // Select register: the reserved bit is dropped, flags only clear
    if (select_wr) begin
      next_s.card_detect_level_select = select_new[CD_LEVEL_BIT];
      next_s.output_enable_level_select = select_new[OE_LEVEL_BIT];
      next_s.output_enable_irq_enable = select_new[OE_EN_BIT];
      next_s.card_detect_irq_enable = select_new[CD_EN_BIT];
      next_s.rx_wake_irq_enable = select_new[RX_EN_BIT];
    end
    if (prio_wr) begin
      next_s.prio_low = prio_new[PRIO_LOW_WIDTH-1:0]; // RULE9
    end

    // Edge trackers
    next_s.oe_prev = oe_active;
    next_s.rx_prev = rx_sync;

    // Synchronous reset
    if (RESET) begin
      next_s = '0;
      next_s.card_detect_level_select = SELECT_RESET[CD_LEVEL_BIT];
      next_s.output_enable_level_select = SELECT_RESET[OE_LEVEL_BIT];
      next_s.output_enable_irq_enable = SELECT_RESET[OE_EN_BIT]; // RULE7
      next_s.card_detect_irq_enable = SELECT_RESET[CD_EN_BIT];
      next_s.rx_wake_irq_enable = SELECT_RESET[RX_EN_BIT];
      next_s.prio_low = PRIO_LOW_RESET; // RULE10
      next_s.irq_mask = IRQ_MASK_RESET;
    end
  end

  // Writing zero to a flag clears it; writing one leaves it alone
  assign flag_clear[FLAG_CD] = select_wr & !select_new[CD_FLAG_BIT]; // RULE3
  assign flag_clear[FLAG_RX] = select_wr & !select_new[RX_FLAG_BIT];

  // State register
  always_ff @(posedge CLOCK) begin
    s <= next_s;
  end

  // Bus handshakes: one write and one read outstanding at most
  assign AWREADY = !s.aw_got & !s.b_valid;
  assign WREADY = !s.w_got & !s.b_valid;
  assign BVALID = s.b_valid;
  assign BRESP = s.b_resp;
  assign ARREADY = !s.r_valid;
  assign RVALID = s.r_valid;
  assign RDATA = s.r_data;
  assign RRESP = s.r_resp;

  // Requests to the core, gated by their enables
  assign CARD_DETECT_IRQ = flags[FLAG_CD] // RULE3
                           & s.card_detect_irq_enable; // RULE4 RULE5
  assign EXTERNAL_REQUEST_ONE = oe_active & s.output_enable_irq_enable; // RULE6
  assign RX_WAKE_IRQ = flags[FLAG_RX] & s.rx_wake_irq_enable;
  assign PRIORITY_LOW = s.prio_low; // RULE9
  // Level interrupt while any unmasked event is pending
  assign IRQ = |(status & s.irq_mask);

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  a_low_level_flag: assert property ( // RULE1
    !s.card_detect_level_select && !card_sync |=> flags[FLAG_CD]
  ) else $error("card flag missed low level");

  a_high_level_flag: assert property ( // RULE2
    s.card_detect_level_select && card_sync |=> flags[FLAG_CD]
  ) else $error("card flag missed high level");

  a_card_flag_hold: assert property ( // RULE3
    flags[FLAG_CD] && !flag_clear[FLAG_CD] |=> flags[FLAG_CD]
  ) else $error("card flag dropped without clear");

  a_card_fwd_gate: assert property ( // RULE4
    CARD_DETECT_IRQ |-> s.card_detect_irq_enable && flags[FLAG_CD]
  ) else $error("card request passed while disabled");

  a_card_block: assert property ( // RULE5
    !s.card_detect_irq_enable |-> !CARD_DETECT_IRQ
  ) else $error("card request not blocked");

  a_ext_one_gate: assert property ( // RULE6
    EXTERNAL_REQUEST_ONE == (oe_active && s.output_enable_irq_enable)
  ) else $error("external one request wrong");

  a_select_reset: assert property ( // RULE7
    @(posedge CLOCK) disable iff (1'b0) RESET |=> select_read == SELECT_RESET
  ) else $error("select register reset value wrong");

  a_prio_write: assert property ( // RULE9
    prio_wr |=> PRIORITY_LOW == $past(prio_new[PRIO_LOW_WIDTH-1:0])
  ) else $error("priority low write lost");

  a_prio_reset: assert property ( // RULE10
    @(posedge CLOCK) disable iff (1'b0)
    RESET |=> PRIORITY_LOW == PRIO_LOW_RESET ##1 prio_read[7:5] == 3'h0
  ) else $error("priority low reset wrong");

  a_write_answer: assert property (
    do_write |=> BVALID
  ) else $error("write not answered");

endmodule
`default_nettype wire

// File: rtl/wakeup_irq_pkg.sv
// Functional notes
// RULE1: Level select clear: low card input raises
// RULE2: Level select set: high card input raises
// RULE3: Card flag hardware set, held until cleared
// RULE4: Card interrupt forwarded only while enabled
// RULE5: Card interrupt blocked while enable cleared
// RULE6: External one request passes only while enabled
// RULE7: Select register resets to 0000 0100b
// RULE8: Software never sets reserved bits
// RULE9: Five low priority bits, one per source
// RULE10: Priority low resets zero, bit addressable
package wakeup_irq_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] SELECT_OFFSET = 8'h00;
  localparam logic [7:0] PRIO_LOW_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
  localparam logic [7:0] BIT_OP_OFFSET = 8'h10;

  // Source select register fields
  localparam int CD_LEVEL_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int CD_FLAG_BIT = 5;
  localparam int RX_FLAG_BIT = 4;
  localparam int OE_LEVEL_BIT = 3;
  localparam int OE_EN_BIT = 2;
  localparam int CD_EN_BIT = 1;
  localparam int RX_EN_BIT = 0;
  localparam logic [7:0] SELECT_RESET = 8'h04;

  // Sticky flags of the select register: index 1 card, index 0 receive
  localparam int FLAG_COUNT = 2;
  localparam int FLAG_CD = 1;
  localparam int FLAG_RX = 0;
  localparam logic [1:0] FLAG_RESET = 2'h0;

  // Low priority register
  localparam int PRIO_LOW_WIDTH = 5;
  localparam logic [4:0] PRIO_LOW_RESET = 5'h00;

  // Event status and mask layout
  localparam int EVENT_COUNT = 3;
  localparam int EV_CD = 0;
  localparam int EV_OE = 1;
  localparam int EV_RX = 2;
  localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Single bit operation fields
  localparam int BIT_OP_TARGET_BIT = 3;
  localparam int BIT_OP_VALUE_BIT = 4;

  // Pin synchroniser reset level: every pin starts at its idle level
  // (card and output enable inactive high, receive line idle high), so
  // no false detection or edge follows reset
  localparam logic [2:0] PIN_SYNC_RESET = 3'h7;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for asynchronous pins
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1; // Metastable stage, read only by stage2
    logic [WIDTH-1:0] stage2; // Settled copy
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // Shift the pins through both stages
  always_comb begin
    next_s = s;
    next_s.stage1 = pin_in;
    next_s.stage2 = s.stage1;
    if (RESET) begin
      next_s.stage1 = RESET_VALUE;
      next_s.stage2 = RESET_VALUE;
    end
  end

  // State register
  always_ff @(posedge CLOCK) begin
    s <= next_s;
  end

  assign pin_out = s.stage2;

endmodule
`default_nettype wire

// File: rtl/sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky flag bank: set wins over a clear in the same cycle
module sticky_flags #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] flag
);

  typedef struct packed {
    logic [WIDTH-1:0] flag; // Held flags
  } flag_state_t;

  flag_state_t s;
  flag_state_t next_s;

  // Clear first, then set, so an arriving event is never lost
  always_comb begin
    next_s = s;
    next_s.flag = (s.flag & ~clear_in) | set_in;
    if (RESET) begin
      next_s.flag = RESET_VALUE;
    end
  end

  // State register
  always_ff @(posedge CLOCK) begin
    s <= next_s;
  end

  assign flag = s.flag;

endmodule
`default_nettype wire

// File: dv/core_vector_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural stand-in for the core's vectoring logic
module core_vector_model #(
  parameter logic EXT_ONE_PRIO_HIGH = 1'b0 // High half held outside here
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic card_irq,
  input wire logic ext_irq,
  input wire logic rx_irq,
  input wire logic [4:0] prio_low,
  output logic [2:0] pending,
  output logic [1:0] ext_one_level
);
  // Requests sampled once per clock, as the core polls them
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pending <= 3'h0;
    end else begin
      pending <= {rx_irq, ext_irq, card_irq};
    end
  end
  // Low bit pairs with the high bit to form the level
  assign ext_one_level = {EXT_ONE_PRIO_HIGH, prio_low[2]};
endmodule
`default_nettype wire

// File: dv/wakeup_irq_select_priority_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wakeup_irq_select_priority_tb;
  import wakeup_irq_pkg::*;
  logic CLOCK = 0, RESET = 1;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic [3:0] WSTRB = 0;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [1:0] BRESP, RRESP, rs, lvl;
  logic [31:0] RDATA, rd;
  // Card idle high, output enable low, receive line idle high
  logic CARD = 1, OE = 0, RX = 1;
  logic CD_IRQ, EXT_ONE, RX_IRQ;
  logic [4:0] PRIO;
  logic [2:0] pend;
  int err_count = 0, n_tests = 0;
  always #12.5 CLOCK = ~CLOCK;
  wakeup_irq_select_priority dut (.CLOCK(CLOCK), .RESET(RESET),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .CARD_DETECT_INPUT(CARD), .OUTPUT_ENABLE_INPUT(OE),
    .RX_WAKE_INPUT(RX), .CARD_DETECT_IRQ(CD_IRQ),
    .EXTERNAL_REQUEST_ONE(EXT_ONE), .RX_WAKE_IRQ(RX_IRQ),
    .PRIORITY_LOW(PRIO), .IRQ(IRQ));
  core_vector_model core (.CLOCK(CLOCK), .RESET(RESET), .card_irq(CD_IRQ),
    .ext_irq(EXT_ONE), .rx_irq(RX_IRQ), .prio_low(PRIO), .pending(pend),
    .ext_one_level(lvl));
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Handshakes are sampled mid-cycle, where they are settled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    int i;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    b_ok = 0;
    for (i = 0; i < 40 && !b_ok; i++) begin
      @(negedge CLOCK);
      aw_ok = AWVALID && AWREADY;
      w_ok = WVALID && WREADY;
      b_ok = BVALID;
      rs = BRESP;
      @(posedge CLOCK);
      if (aw_ok) AWVALID <= 0;
      if (w_ok) WVALID <= 0;
      if (b_ok) BREADY <= 0;
    end
    if (!b_ok) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic axi_read(input logic [7:0] a);
    logic ar_ok, r_ok;
    int i;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    r_ok = 0;
    for (i = 0; i < 40 && !r_ok; i++) begin
      @(negedge CLOCK);
      ar_ok = ARVALID && ARREADY;
      r_ok = RVALID;
      rd = RDATA;
      rs = RRESP;
      @(posedge CLOCK);
      if (ar_ok) ARVALID <= 0;
      if (r_ok) RREADY <= 0;
    end
    if (!r_ok) begin
      err_count++;
      stop_test();
    end
  endtask
  // Read a register and compare it
  task automatic rd_chk(input string n, input logic [7:0] a, logic [31:0] e);
    axi_read(a);
    check(n, rd, e);
  endtask
  // Pins need two sync edges plus one for the flag
  task automatic settle();
    repeat (5) @(posedge CLOCK);
  endtask
  // Main sequence; no write ever sets the reserved bit 6
  initial begin
    repeat (2) @(posedge CLOCK);
    RESET <= 0;
    settle();
    axi_read(SELECT_OFFSET);
    // Card and receive pins idle at reset, so no flag may be set here
    check("select reset", rd, 32'h04);
    rd_chk("prio reset", PRIO_LOW_OFFSET, 32'h0);
    check("ext one on", EXT_ONE, 1);
    axi_write(SELECT_OFFSET, 32'h04);
    axi_write(IRQ_STATUS_OFFSET, 32'h07);
    axi_write(SELECT_OFFSET, 32'h00);
    check("ext one off", EXT_ONE, 0);
    CARD <= 0;
    settle();
    rd_chk("card low", SELECT_OFFSET, 32'h20);
    check("card blocked", CD_IRQ, 0);
    axi_write(SELECT_OFFSET, 32'h22);
    check("card fwd", CD_IRQ, 1);
    @(posedge CLOCK);
    check("core card", pend, 3'h1);
    CARD <= 1;
    settle();
    rd_chk("card sticky", SELECT_OFFSET, 32'h22);
    axi_read(IRQ_STATUS_OFFSET);
    check("status card", rd[0], 1);
    check("irq masked", IRQ, 0);
    axi_write(IRQ_MASK_OFFSET, 32'h01);
    check("irq unmasked", IRQ, 1);
    axi_write(IRQ_STATUS_OFFSET, 32'h01);
    check("irq cleared", IRQ, 0);
    axi_write(SELECT_OFFSET, 32'h02);
    rd_chk("card clear", SELECT_OFFSET, 32'h02);
    check("card drop", CD_IRQ, 0);
    axi_write(SELECT_OFFSET, 32'h82);
    settle();
    rd_chk("card high", SELECT_OFFSET, 32'hA2);
    CARD <= 0;
    settle();
    axi_write(SELECT_OFFSET, 32'h85);
    rd_chk("high quiet", SELECT_OFFSET, 32'h85);
    check("ext one back", EXT_ONE, 1);
    RX <= 0;
    settle();
    rd_chk("rx flag", SELECT_OFFSET, 32'h95);
    check("core rx", pend, 3'h6);
    axi_write(SELECT_OFFSET, 32'h9D);
    check("oe level hi", EXT_ONE, 0);
    OE <= 1;
    settle();
    check("oe high on", EXT_ONE, 1);
    axi_write(PRIO_LOW_OFFSET, 32'h1F);
    rd_chk("prio all", PRIO_LOW_OFFSET, 32'h1F);
    axi_write(PRIO_LOW_OFFSET, 32'h0A);
    check("prio port", PRIO, 5'h0A);
    check("ext1 level", lvl, 2'h0);
    // Bit op: index 2, priority target, value one
    axi_write(BIT_OP_OFFSET, 32'h1A);
    rd_chk("prio bit op", PRIO_LOW_OFFSET, 32'h0E);
    check("ext1 level b", lvl, 2'h1);
    // Bit op: index 1, select target, value one sets the card enable
    axi_write(BIT_OP_OFFSET, 32'h11);
    rd_chk("select bit op", SELECT_OFFSET, 32'h9F);
    check("card no flag", CD_IRQ, 0);
    axi_read(8'h20);
    check("unmapped rd", rd, 32'h0);
    check("unmapped rd resp", rs, RESP_SLVERR);
    axi_write(8'h20, 32'h1);
    check("unmapped wr", rs, RESP_SLVERR);
    stop_test();
  end
endmodule
`default_nettype wire
